/* shared/rmbc_consts.svh */
/*
 * Constants of the reset, mode and bias control block: register offsets,
 * field positions, reset values per strap preset and timing figures.
 * Assumes it is included by bare name from the package and the design files.
 */
`ifndef RMBC_CONSTS_SVH
`define RMBC_CONSTS_SVH

// Register port geometry.
`define RMBC_ADDR_W 6
`define RMBC_DATA_W 8

// Register offsets.
`define RMBC_OFS_POWER_MODE 6'h00
`define RMBC_OFS_CONV_LOW_POWER 6'h07
`define RMBC_OFS_RX_BIAS 6'h13

// Field positions.
`define RMBC_SOFT_RESET_BIT 5
`define RMBC_CONV_LOW_POWER_BIT 4
`define RMBC_CGA_HI 7
`define RMBC_CGA_LO 5
`define RMBC_FGA_HI 4
`define RMBC_FGA_LO 3
`define RMBC_CONV_HI 2
`define RMBC_CONV_LO 0

// Converter bias code that the low-power bit stands for.
`define RMBC_CONV_LOW_POWER_CODE 3'h3

// Reset values; the bias register is the same for every preset.
`define RMBC_RX_BIAS_RESET 8'h00
`define RMBC_PMC_DEF_HALF_SPI 8'h00
`define RMBC_PMC_DEF_HALF_LEGACY 8'h01
`define RMBC_PMC_DEF_FULL_LEGACY 8'h02
`define RMBC_PMC_DEF_FULL_SPI 8'h00
`define RMBC_CLP_DEF_HALF_SPI 8'h00
`define RMBC_CLP_DEF_HALF_LEGACY 8'h00
`define RMBC_CLP_DEF_FULL_LEGACY 8'h10
`define RMBC_CLP_DEF_FULL_SPI 8'h00

// Timing at 200 MHz.
`define RMBC_CLK_PERIOD_PS 5000
`define RMBC_RESET_MIN_NS 50
`define RMBC_RESET_MIN_CYC ((`RMBC_RESET_MIN_NS * 1000 + `RMBC_CLK_PERIOD_PS - 1) / `RMBC_CLK_PERIOD_PS)

`endif

/* shared/rmbc_pkg.sv */
/*
 * Types of the reset, mode and bias control block.
 * Assumes rmbc_consts.svh is on the include path.
 */
`include "rmbc_consts.svh"

package rmbc_pkg;

    // Default register preset picked by the two straps.
    typedef enum logic [1:0] {
        RMBC_PRESET_HALF_SPI,
        RMBC_PRESET_HALF_LEGACY,
        RMBC_PRESET_FULL_LEGACY,
        RMBC_PRESET_FULL_SPI
    } rmbc_preset_e;

    // Strap levels as caught at power-up.
    typedef struct packed {
        logic duplex;
        logic preset;
    } rmbc_straps_s;

    // Receive bias control word, in register bit order.
    typedef struct packed {
        logic [2:0] coarse;
        logic [1:0] fine;
        logic [2:0] conv;
    } rmbc_bias_s;

    // Sequencer states.
    typedef enum logic [1:0] {
        RMBC_BOOT,
        RMBC_IDLE,
        RMBC_HELD,
        RMBC_CAL
    } rmbc_state_e;

endpackage : rmbc_pkg

/* hdl/rmbc_defaults.sv */
/*
 * Preset table: maps the strap-selected preset to the default values of the
 * mode registers, with registered read data.
 * Assumes the preset input is stable for a cycle before its data is used.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rmbc_consts.svh"

module rmbc_defaults
    import rmbc_pkg::*;
(
    input wire logic clock,
    input wire rmbc_preset_e preset,
    output logic [7:0] pmc_default,
    output logic [7:0] clp_default
);

    // Combinational table look-up.
    logic [7:0] next_pmc;
    logic [7:0] next_clp;

    always_comb begin
        unique case (preset)
            RMBC_PRESET_HALF_SPI: begin
                next_pmc = `RMBC_PMC_DEF_HALF_SPI;
                next_clp = `RMBC_CLP_DEF_HALF_SPI;
            end
            RMBC_PRESET_HALF_LEGACY: begin
                next_pmc = `RMBC_PMC_DEF_HALF_LEGACY;
                next_clp = `RMBC_CLP_DEF_HALF_LEGACY;
            end
            RMBC_PRESET_FULL_LEGACY: begin
                next_pmc = `RMBC_PMC_DEF_FULL_LEGACY;
                next_clp = `RMBC_CLP_DEF_FULL_LEGACY;
            end
            RMBC_PRESET_FULL_SPI: begin
                next_pmc = `RMBC_PMC_DEF_FULL_SPI;
                next_clp = `RMBC_CLP_DEF_FULL_SPI;
            end
        endcase
    end

    // Read data leaves through a register, like a small ROM.
    always_ff @(posedge clock) begin
        pmc_default <= next_pmc;
        clp_default <= next_clp;
    end

endmodule : rmbc_defaults

`default_nettype wire

/* hdl/rmbc_top.sv */
/*
 * Reset, mode and bias control: strap capture, hardware and software reset
 * sequencing, calibration start and the receive bias register.
 * Assumes the reset pin and register port are synchronous to clock, and
 * that sys_rst is held for at least two edges at power-up.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rmbc_consts.svh"

module rmbc_top
    import rmbc_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic reset_pin_n,
    input wire logic duplex_strap,
    input wire logic preset_strap,
    input wire logic serial_port_select_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [`RMBC_ADDR_W-1:0] reg_addr,
    input wire logic [`RMBC_DATA_W-1:0] reg_wdata,
    input wire logic cal_done,
    output logic [`RMBC_DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    output logic full_duplex,
    output logic [2:0] coarse_gain_amp_bias,
    output logic [1:0] fine_gain_amp_bias,
    output logic [2:0] converter_bias,
    output logic cal_start,
    output logic cal_busy
);

    // Straps caught while the power-up reset is applied.
    rmbc_straps_s straps;
    // Sequencer state.
    rmbc_state_e state;
    // Mode registers.
    logic [7:0] power_mode_control;
    logic [7:0] converter_low_power_control;
    rmbc_bias_s rx_bias_adjust;
    // Soft reset request, one cycle long.
    logic soft_pending;
    // Defaults delivered by the preset table.
    logic [7:0] pmc_default;
    logic [7:0] clp_default;

    // Decode wires.
    wire port_enabled = ~serial_port_select_n;
    wire pin_low = ~reset_pin_n;
    wire access_ok = port_enabled && !pin_low && state != RMBC_BOOT;
    wire wr_ok = reg_wr && access_ok;
    wire hit_pmc = reg_addr == `RMBC_OFS_POWER_MODE;
    wire hit_clp = reg_addr == `RMBC_OFS_CONV_LOW_POWER;
    wire hit_bias = reg_addr == `RMBC_OFS_RX_BIAS;
    wire soft_req = wr_ok && hit_pmc && reg_wdata[`RMBC_SOFT_RESET_BIT];
    // Defaults load on power-up, while the pin is low, and on soft reset.
    wire load_defaults = state == RMBC_BOOT || pin_low || soft_pending;
    wire rmbc_preset_e preset_sel = rmbc_preset_e'({straps.duplex, straps.preset});
    wire [2:0] next_conv_bias = converter_low_power_control[`RMBC_CONV_LOW_POWER_BIT]
        ? `RMBC_CONV_LOW_POWER_CODE : rx_bias_adjust.conv;
    wire [7:0] rd_mux = hit_pmc ? power_mode_control
        : hit_clp ? converter_low_power_control
        : hit_bias ? rx_bias_adjust
        : 8'h00;

    // Preset table; its outputs are ready one edge after the straps settle.
    rmbc_defaults u_defaults (
        .clock(clock),
        .preset(preset_sel),
        .pmc_default(pmc_default),
        .clp_default(clp_default)
    );

    // Straps are sampled only under the power-up reset, then frozen.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            straps <= '{duplex: duplex_strap, preset: preset_strap};
        end
    end

    // Sequencer: boot, idle, pin held low, calibration running.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state <= RMBC_BOOT;
        end else begin
            unique case (state)
                RMBC_BOOT: begin
                    state <= pin_low ? RMBC_HELD : RMBC_IDLE;
                end
                RMBC_IDLE: begin
                    if (pin_low) begin
                        state <= RMBC_HELD;
                    end
                end
                RMBC_HELD: begin
                    // Calibration waits for the pin to come back high.
                    if (!pin_low) begin
                        state <= RMBC_CAL;
                    end
                end
                RMBC_CAL: begin
                    // A new low pulse aborts and restarts the sequence.
                    if (pin_low) begin
                        state <= RMBC_HELD;
                    end else if (cal_done) begin
                        state <= RMBC_IDLE;
                    end
                end
            endcase
        end
    end

    // Soft reset request lasts one cycle, so the bit clears itself.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            soft_pending <= 1'b0;
        end else begin
            soft_pending <= soft_req && !soft_pending;
        end
    end

    // Mode registers; the soft reset bit is never stored.
    // Note that nothing here touches the transmit filter state: flushing it
    // is left to the data path.
    always_ff @(posedge clock) begin
        if (sys_rst || load_defaults) begin
            power_mode_control <= pmc_default;
            converter_low_power_control <= clp_default;
            rx_bias_adjust <= `RMBC_RX_BIAS_RESET;
        end else if (wr_ok) begin
            if (hit_pmc && !soft_req) begin
                power_mode_control <= reg_wdata;
            end
            if (hit_clp) begin
                converter_low_power_control <= reg_wdata;
            end
            if (hit_bias) begin
                rx_bias_adjust <= reg_wdata;
            end
        end
    end

    // Register read port: one-cycle answer, unmapped offsets read zero.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd && access_ok;
            reg_rdata <= (reg_rd && access_ok) ? rd_mux : 8'h00;
        end
    end

    // Block outputs, all registered.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            full_duplex <= 1'b0;
            coarse_gain_amp_bias <= 3'h0;
            fine_gain_amp_bias <= 2'h0;
            converter_bias <= 3'h0;
            cal_start <= 1'b0;
            cal_busy <= 1'b0;
        end else begin
            full_duplex <= straps.duplex;
            coarse_gain_amp_bias <= rx_bias_adjust.coarse;
            fine_gain_amp_bias <= rx_bias_adjust.fine;
            converter_bias <= next_conv_bias;
            // Only the pin path reaches the calibration start.
            cal_start <= state == RMBC_HELD && !pin_low;
            cal_busy <= state == RMBC_HELD ? !pin_low
                : state == RMBC_CAL && !pin_low && !cal_done;
        end
    end

    // Checks.
    default clocking chk_clk @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence pin_rise_s;
        state == RMBC_HELD && !pin_low;
    endsequence

    sequence cal_pulse_s;
        cal_start && cal_busy;
    endsequence

    chk_bias_fields: assert property (
        wr_ok && hit_bias && !load_defaults ##2 !load_defaults[*1]
        |-> coarse_gain_amp_bias == $past(reg_wdata[`RMBC_CGA_HI:`RMBC_CGA_LO], 2)
            && fine_gain_amp_bias == $past(reg_wdata[`RMBC_FGA_HI:`RMBC_FGA_LO], 2))
        else $error("bias fields do not follow the written value");

    chk_bias_reset: assert property (
        load_defaults |=> rx_bias_adjust == `RMBC_RX_BIAS_RESET)
        else $error("bias register not cleared by reset");

    chk_conv_low_power: assert property (
        converter_low_power_control[`RMBC_CONV_LOW_POWER_BIT]
        |=> converter_bias == `RMBC_CONV_LOW_POWER_CODE)
        else $error("low-power bit does not force converter code");

    chk_duplex_strap: assert property (
        !$past(sys_rst) |-> full_duplex == $past(straps.duplex))
        else $error("duplex output does not follow strap");

    chk_port_disabled: assert property (
        serial_port_select_n && reg_rd |=> !reg_rvalid)
        else $error("read answered with serial port deselected");

    chk_soft_no_cal: assert property (
        soft_pending && state == RMBC_IDLE |=> !cal_start)
        else $error("soft reset started calibration");

    chk_pin_defaults: assert property (
        pin_low && state != RMBC_BOOT |=> power_mode_control == $past(pmc_default)
            && rx_bias_adjust == `RMBC_RX_BIAS_RESET)
        else $error("pin low did not restore defaults");

    chk_cal_on_rise: assert property (
        pin_rise_s |=> cal_pulse_s ##1 !cal_start)
        else $error("calibration start not a single pulse on pin rise");

    chk_no_cal_held: assert property (
        pin_low |=> !cal_start)
        else $error("calibration started while pin held low");

    chk_soft_clears: assert property (
        soft_req && !soft_pending |=> soft_pending ##1 !soft_pending
            && !power_mode_control[`RMBC_SOFT_RESET_BIT])
        else $error("soft reset bit did not clear itself");

endmodule : rmbc_top

`default_nettype wire

/* bench/rmbc_host_model.sv */
/*
 * Partner model: the host's reset circuit and the calibration engine.
 * Assumes it shares the block's clock and sees the block's cal_start pulse.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rmbc_consts.svh"

module rmbc_host_model #(
    parameter int PWRUP_CYC = 40
) (
    input wire logic clock,
    input wire logic hw_req,
    input wire logic cal_start,
    input wire logic [3:0] cal_lat,
    output logic reset_pin_n,
    output logic cal_done
);
    // Cycles left with the pin low; power-up time is scaled down to keep runs short.
    int unsigned low_cnt = PWRUP_CYC;
    // Cycles left until calibration reports done.
    int unsigned cal_cnt = 0;

    // A request holds the pin low for exactly the minimum width, never shorter.
    always @(posedge clock) begin
        if (hw_req) begin
            low_cnt <= `RMBC_RESET_MIN_CYC;
        end else if (low_cnt != 0) begin
            low_cnt <= low_cnt - 1;
        end
    end
    assign reset_pin_n = (low_cnt == 0);

    // Calibration answers after a selectable delay with a one-cycle done pulse.
    always @(posedge clock) begin
        if (cal_start) begin
            cal_cnt <= cal_lat + 1;
        end else if (cal_cnt != 0) begin
            cal_cnt <= cal_cnt - 1;
        end
    end
    assign cal_done = (cal_cnt == 1);
endmodule : rmbc_host_model
`default_nettype wire

/* bench/reset_mode_bias_control_tb.sv */
/*
 * Self-checking bench: strap presets, bias register, soft and pin resets.
 * Assumes the block and the host model share one 200 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rmbc_consts.svh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end

module reset_mode_bias_control_tb;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic duplex_strap = 1'b0;
    logic preset_strap = 1'b0;
    logic serial_port_select_n = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [5:0] reg_addr = 6'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic hw_req = 1'b0;
    logic [3:0] cal_lat = 4'h1;
    wire reset_pin_n;
    wire cal_done;
    logic [7:0] reg_rdata;
    logic reg_rvalid, full_duplex, cal_start, cal_busy;
    logic [2:0] coarse_gain_amp_bias, converter_bias;
    logic [1:0] fine_gain_amp_bias;
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;
    int n_cal = 0;
    int n0;
    // Default values per preset code {duplex, preset}.
    logic [7:0] pmc_x [4] = '{8'h00, 8'h01, 8'h02, 8'h00};
    logic [7:0] clp_x [4] = '{8'h00, 8'h00, 8'h10, 8'h00};

    always #2.5 clock = ~clock;

    rmbc_top u_rmbc_top (.clock(clock), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n),
        .duplex_strap(duplex_strap), .preset_strap(preset_strap),
        .serial_port_select_n(serial_port_select_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .cal_done(cal_done),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .full_duplex(full_duplex),
        .coarse_gain_amp_bias(coarse_gain_amp_bias), .fine_gain_amp_bias(fine_gain_amp_bias),
        .converter_bias(converter_bias), .cal_start(cal_start), .cal_busy(cal_busy));
    rmbc_host_model u_rmbc_host_model (.clock(clock), .hw_req(hw_req), .cal_start(cal_start),
        .cal_lat(cal_lat), .reset_pin_n(reset_pin_n), .cal_done(cal_done));

    task automatic close_out;
        if (num_errors == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out

    // Counts calibration starts and cuts a hang short.
    always @(posedge clock) begin
        cycles++;
        if (cal_start === 1'b1) begin
            n_cal++;
        end
        if (cycles == 4000) begin
            num_errors++;
            close_out();
        end
    end

    // One-cycle write strobe, launched and dropped on falling edges.
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clock);
        reg_wr = 1'b0;
    endtask : wr

    // One-cycle read; the answer stands for the cycle after the taking edge, so it is
    // looked at on the falling edge in the middle of that cycle.
    task automatic rd(input logic [5:0] a, input logic [7:0] e, input logic v);
        @(negedge clock);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clock);
        reg_rd = 1'b0;
        `CHK(reg_rvalid, v)
        if (v) `CHK(reg_rdata, e)
    endtask : rd

    // Bias outputs land one edge after the write edge; after a soft reset they land two edges after it.
    task automatic settle;
        repeat (2) @(posedge clock);
        #1;
    endtask : settle

    task automatic power_up(input logic [1:0] p);
        @(negedge clock);
        sys_rst = 1'b1;
        duplex_strap = p[1];
        preset_strap = p[0];
        repeat (12) @(negedge clock);
        sys_rst = 1'b0;
        repeat (3) @(negedge clock);
    endtask : power_up

    // Waits for the calibration start, then checks busy spans the answer delay.
    task automatic wait_cal(input int lat);
        int n;
        n = 0;
        cal_lat = lat[3:0];
        while (cal_start !== 1'b1 && n < 60) begin
            @(negedge clock);
            n++;
        end
        `CHK(n < 60, 1'b1)
        `CHK(reset_pin_n, 1'b1)
        repeat (lat) @(negedge clock);
        `CHK(cal_busy, 1'b1)
        repeat (3) @(negedge clock);
        `CHK(cal_busy, 1'b0)
    endtask : wait_cal

    initial begin
        // Every strap preset, including the two legacy ones.
        for (int p = 0; p < 4; p++) begin
            power_up(p[1:0]);
            if (p == 0) wait_cal(1);
            `CHK(full_duplex, p[1])
            rd(`RMBC_OFS_POWER_MODE, pmc_x[p], 1'b1);
            rd(`RMBC_OFS_CONV_LOW_POWER, clp_x[p], 1'b1);
            rd(`RMBC_OFS_RX_BIAS, 8'h00, 1'b1);
            `CHK(converter_bias, clp_x[p][4] ? 3'h3 : 3'h0)
        end
        wr(`RMBC_OFS_RX_BIAS, 8'ha5);
        settle();
        `CHK({coarse_gain_amp_bias, fine_gain_amp_bias, converter_bias}, 8'ha5)
        wr(`RMBC_OFS_CONV_LOW_POWER, 8'h10);
        settle();
        `CHK(converter_bias, 3'h3)
        rd(`RMBC_OFS_RX_BIAS, 8'ha5, 1'b1);
        rd(6'h3f, 8'h00, 1'b1);
        // A deselected port neither stores nor answers.
        @(negedge clock);
        serial_port_select_n = 1'b1;
        wr(`RMBC_OFS_RX_BIAS, 8'h77);
        rd(`RMBC_OFS_RX_BIAS, 8'h00, 1'b0);
        serial_port_select_n = 1'b0;
        rd(`RMBC_OFS_RX_BIAS, 8'ha5, 1'b1);
        // Soft reset restores defaults and starts no calibration.
        n0 = n_cal;
        wr(`RMBC_OFS_POWER_MODE, 8'h20);
        settle();
        `CHK({coarse_gain_amp_bias, fine_gain_amp_bias, converter_bias}, 8'h00)
        rd(`RMBC_OFS_POWER_MODE, 8'h00, 1'b1);
        rd(`RMBC_OFS_CONV_LOW_POWER, 8'h00, 1'b1);
        `CHK(n_cal, n0)
        // Pin reset mid-run, with a write attempted while the pin is low.
        wr(`RMBC_OFS_RX_BIAS, 8'hff);
        settle();
        @(negedge clock);
        hw_req = 1'b1;
        @(negedge clock);
        hw_req = 1'b0;
        wr(`RMBC_OFS_RX_BIAS, 8'h55);
        settle();
        `CHK({coarse_gain_amp_bias, fine_gain_amp_bias, converter_bias}, 8'h00)
        `CHK({reset_pin_n, cal_start}, 2'b00)
        wait_cal(6);
        rd(`RMBC_OFS_RX_BIAS, 8'h00, 1'b1);
        close_out();
    end
endmodule : reset_mode_bias_control_tb
`default_nettype wire
